//--- rtl/timer_pkg.sv
// Constants for the top-compare, compare-D, interrupt-flag and dead-time block.
// Assumes byte-wide register access and a 10-bit counter.
package timer_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h20;
    localparam logic [7:0] ADDR_HIGH_BYTE = 8'h21;
    localparam logic [7:0] ADDR_CMP_A = 8'h22;
    localparam logic [7:0] ADDR_CMP_B = 8'h23;
    localparam logic [7:0] ADDR_TOP = 8'h24;
    localparam logic [7:0] ADDR_CMP_D = 8'h25;
    localparam logic [7:0] ADDR_DEAD_TIME = 8'h26;
    localparam logic [7:0] ADDR_MODE = 8'h27;
    localparam logic [7:0] ADDR_FLAGS = 8'h38;
    localparam logic [7:0] ADDR_MASK = 8'h39;

    // Reset values
    localparam logic [9:0] COUNT_RESET = 10'h000;
    localparam logic [9:0] TOP_RESET = 10'h0ff;
    localparam logic [9:0] CMP_RESET = 10'h000;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] DT_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] HIGH_RESET = 2'h0;

    // Lowest value the top compare may hold
    localparam logic [9:0] TOP_MIN = 10'h003;

    // Event index: 0 compare A, 1 compare B, 2 compare D, 3 overflow
    localparam int NUM_EV = 4;
    localparam int EV_A = 0;
    localparam int EV_B = 1;
    localparam int EV_D = 2;
    localparam int EV_OVF = 3;
    localparam int FLAG_POS [NUM_EV] = '{6, 5, 7, 2};
    localparam logic [7:0] EV_VEC [NUM_EV] = '{8'h03, 8'h09, 8'h10, 8'h04};
    localparam logic [7:0] VEC_NONE = 8'h00;

    // Mode register fields
    localparam int MODE_RUN_BIT = 0;
    localparam int MODE_SEL_LSB = 1;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_FAST = 2'h1;
    localparam logic [1:0] MODE_PFC = 2'h2;

    // Dead-time nibbles
    localparam int DT_TRUE_LSB = 4;
    localparam int DT_COMPL_LSB = 0;
    localparam int NUM_CH = 3;

endpackage

//--- rtl/timer_top_compare_irq_deadtime.sv
// Timer core with top compare, compare channels, interrupt flags and dead time.
// Assumes a prescaler strobe timer_tick and CPU interrupt hand-off on clk_sys.
//
// Summary of operation
// - Normal/fast: top compare match clears counter to zero
// - Top writes below three store three
// - Phase-correct: top compare match reverses count direction
// - Compare-D match only from counting
// - Software count write never matches compare-D
// - Compare-D flag set after synchronization delay
// - Mask bits: D 7, A 6, B 5
// - Request needs global enable, enable, flag
// - Vectors: D 0x10, A 0x03, B 0x09
// - Overflow enable bit 2, vector 0x04
// - Flag bank 0x38, bits 7,6,5,2, reset zero
// - Compare A and B matches set flags
// - Compare flags clear by vector or write-one
// - Normal/fast: overflow flag set at top
// - Phase-correct: overflow flag set at bottom
// - Overflow flag clears by vector or write-one
// - Dead time: high nibble true, low compl
// - Dead time zero to fifteen timer ticks
// - One dead-time setting for all channels
// - Shared high byte for all 10-bit accesses
`timescale 1ns/1ps
`default_nettype none

module timer_top_compare_irq_deadtime (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic timer_tick,
    input wire logic global_irq_en,
    input wire logic irq_ack,
    output logic irq_req,
    output logic [7:0] irq_vector,
    output logic [2:0] out_true,
    output logic [2:0] out_compl
);

    logic [9:0] count;
    logic dir_down;
    logic [1:0] high_byte;
    logic [9:0] top_compare;
    logic [9:0] compare_a;
    logic [9:0] compare_b;
    logic [9:0] compare_d;
    logic [7:0] irq_enable_mask;
    logic [7:0] dead_time_setting;
    logic [7:0] mode_reg;
    logic step_d;
    logic [3:0] match_sync;
    logic [3:0] clear_pend;
    logic [3:0] ev_flag;
    logic [2:0] wave;
    logic [2:0] wave_prev;
    logic [3:0] dt_cnt [timer_pkg::NUM_CH];

    // Register decode
    wire sel_count = reg_addr == timer_pkg::ADDR_COUNT_LOW;
    wire sel_high = reg_addr == timer_pkg::ADDR_HIGH_BYTE;
    wire sel_a = reg_addr == timer_pkg::ADDR_CMP_A;
    wire sel_b = reg_addr == timer_pkg::ADDR_CMP_B;
    wire sel_top = reg_addr == timer_pkg::ADDR_TOP;
    wire sel_d = reg_addr == timer_pkg::ADDR_CMP_D;
    wire sel_dt = reg_addr == timer_pkg::ADDR_DEAD_TIME;
    wire sel_mode = reg_addr == timer_pkg::ADDR_MODE;
    wire sel_flags = reg_addr == timer_pkg::ADDR_FLAGS;
    wire sel_mask = reg_addr == timer_pkg::ADDR_MASK;

    wire wr_count = reg_wr && sel_count;
    wire wr_top = reg_wr && sel_top;
    wire wr_flags = reg_wr && sel_flags;
    wire rd_wide = reg_rd && (sel_count || sel_a || sel_b || sel_top || sel_d);

    // Ten-bit write word from the shared high byte
    wire [9:0] wr_word = {high_byte, reg_wdata};
    wire [9:0] top_write = (wr_word < timer_pkg::TOP_MIN) ? timer_pkg::TOP_MIN : wr_word;

    // Counter stepping
    wire run = mode_reg[timer_pkg::MODE_RUN_BIT];
    wire [1:0] mode_sel = mode_reg[timer_pkg::MODE_SEL_LSB +: 2];
    wire pfc = mode_sel == timer_pkg::MODE_PFC;
    wire at_top = count == top_compare;
    wire at_bottom = count == 10'h000;
    wire step = run && timer_tick && !wr_count;

    wire [9:0] next_count_single = at_top ? 10'h000 : count + 10'h001;
    wire [9:0] next_count_dual = dir_down ?
        (at_bottom ? count + 10'h001 : count - 10'h001) :
        (at_top ? count - 10'h001 : count + 10'h001);
    wire next_dir_dual = dir_down ? !at_bottom : at_top;
    wire [9:0] next_count = pfc ? next_count_dual : next_count_single;
    wire next_dir = pfc ? next_dir_dual : 1'b0;

    wire ovf_single = step && !pfc && at_top;
    wire ovf_dual = step && pfc && dir_down && count == 10'h001;
    wire ovf_event = ovf_single || ovf_dual;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count <= timer_pkg::COUNT_RESET;
            dir_down <= 1'b0;
        end else if (wr_count) begin
            count <= wr_word;
            dir_down <= 1'b0;
        end else if (step) begin
            count <= next_count;
            dir_down <= next_dir;
        end
    end

    // Matches only one cycle after the counter itself moved
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_d <= 1'b0;
        end else begin
            step_d <= step;
        end
    end

    wire [3:0] match;
    assign match[timer_pkg::EV_A] = step_d && count == compare_a;
    assign match[timer_pkg::EV_B] = step_d && count == compare_b;
    assign match[timer_pkg::EV_D] = step_d && count == compare_d;
    assign match[timer_pkg::EV_OVF] = 1'b0;

    // Compare events pass one synchronization stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_sync <= 4'h0;
        end else begin
            match_sync <= match;
        end
    end

    // Writable registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            top_compare <= timer_pkg::TOP_RESET;
            compare_a <= timer_pkg::CMP_RESET;
            compare_b <= timer_pkg::CMP_RESET;
            compare_d <= timer_pkg::CMP_RESET;
            irq_enable_mask <= timer_pkg::MASK_RESET;
            dead_time_setting <= timer_pkg::DT_RESET;
            mode_reg <= timer_pkg::MODE_RESET;
        end else if (reg_wr) begin
            if (sel_top) begin
                top_compare <= top_write;
            end
            if (sel_a) begin
                compare_a <= wr_word;
            end
            if (sel_b) begin
                compare_b <= wr_word;
            end
            if (sel_d) begin
                compare_d <= wr_word;
            end
            if (sel_mask) begin
                irq_enable_mask <= reg_wdata;
            end
            if (sel_dt) begin
                dead_time_setting <= reg_wdata;
            end
            if (sel_mode) begin
                mode_reg <= reg_wdata;
            end
        end
    end

    // Shared high byte: written directly, captured on wide low-byte reads
    wire [9:0] wide_read =
        sel_count ? count :
        sel_a ? compare_a :
        sel_b ? compare_b :
        sel_top ? top_compare : compare_d;
    wire [1:0] next_high_byte =
        (reg_wr && sel_high) ? reg_wdata[1:0] :
        rd_wide ? wide_read[9:8] : high_byte;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            high_byte <= timer_pkg::HIGH_RESET;
        end else begin
            high_byte <= next_high_byte;
        end
    end

    // Event flags, enables and clears
    wire [3:0] ev_en;
    wire [3:0] ev_wclr;
    wire [3:0] ev_set;
    wire [3:0] ev_ack;
    wire [3:0] pending;
    wire [3:0] next_flag;
    wire [7:0] flag_read;

    genvar gi;
    generate
        for (gi = 0; gi < timer_pkg::NUM_EV; gi++) begin : g_ev
            assign ev_en[gi] = irq_enable_mask[timer_pkg::FLAG_POS[gi]];
            assign ev_wclr[gi] = wr_flags && reg_wdata[timer_pkg::FLAG_POS[gi]];
            assign ev_ack[gi] = irq_ack && irq_req && irq_vector == timer_pkg::EV_VEC[gi];
            assign ev_set[gi] = (gi == timer_pkg::EV_OVF) ? ovf_event : match_sync[gi];
            // Set wins over any clear in the same cycle
            assign next_flag[gi] = ev_set[gi] ||
                (ev_flag[gi] && !clear_pend[gi] && !ev_ack[gi]);
            assign pending[gi] = ev_flag[gi] && ev_en[gi];
        end
    endgenerate

    assign flag_read = {ev_flag[timer_pkg::EV_D], ev_flag[timer_pkg::EV_A],
        ev_flag[timer_pkg::EV_B], 2'b00, ev_flag[timer_pkg::EV_OVF], 2'b00};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ev_flag <= 4'h0;
            clear_pend <= 4'h0;
        end else begin
            ev_flag <= next_flag;
            clear_pend <= ev_wclr;
        end
    end

    // Lowest vector number wins; an acked event drops out at once
    wire [3:0] live_pend = pending & ~ev_ack;
    wire [7:0] next_vector =
        live_pend[timer_pkg::EV_A] ? timer_pkg::EV_VEC[timer_pkg::EV_A] :
        live_pend[timer_pkg::EV_OVF] ? timer_pkg::EV_VEC[timer_pkg::EV_OVF] :
        live_pend[timer_pkg::EV_B] ? timer_pkg::EV_VEC[timer_pkg::EV_B] :
        live_pend[timer_pkg::EV_D] ? timer_pkg::EV_VEC[timer_pkg::EV_D] :
        timer_pkg::VEC_NONE;
    wire next_req = global_irq_en && |live_pend;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_req <= 1'b0;
            irq_vector <= timer_pkg::VEC_NONE;
        end else begin
            irq_req <= next_req;
            irq_vector <= next_req ? next_vector : timer_pkg::VEC_NONE;
        end
    end

    // Read data, one cycle after the strobe
    wire [7:0] next_rdata =
        !reg_rd ? 8'h00 :
        (sel_count || sel_a || sel_b || sel_top || sel_d) ? wide_read[7:0] :
        sel_high ? {6'h00, high_byte} :
        sel_dt ? dead_time_setting :
        sel_mode ? mode_reg :
        sel_flags ? flag_read :
        sel_mask ? irq_enable_mask : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Waveforms and dead-time generators
    wire [9:0] ch_cmp [timer_pkg::NUM_CH];
    assign ch_cmp[0] = compare_a;
    assign ch_cmp[1] = compare_b;
    assign ch_cmp[2] = compare_d;
    wire [3:0] dt_true = dead_time_setting[timer_pkg::DT_TRUE_LSB +: 4];
    wire [3:0] dt_compl = dead_time_setting[timer_pkg::DT_COMPL_LSB +: 4];

    generate
        for (gi = 0; gi < timer_pkg::NUM_CH; gi++) begin : g_dt
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    wave[gi] <= 1'b0;
                    wave_prev[gi] <= 1'b0;
                    dt_cnt[gi] <= 4'h0;
                    out_true[gi] <= 1'b0;
                    out_compl[gi] <= 1'b0;
                end else begin
                    wave[gi] <= count < ch_cmp[gi];
                    if (wave[gi] != wave_prev[gi]) begin
                        // Either edge drops both outputs at once; the newly active output waits
                        wave_prev[gi] <= wave[gi];
                        dt_cnt[gi] <= wave[gi] ? dt_true : dt_compl;
                        out_true[gi] <= 1'b0;
                        out_compl[gi] <= 1'b0;
                    end else if (dt_cnt[gi] == 4'h0) begin
                        out_true[gi] <= wave_prev[gi];
                        out_compl[gi] <= !wave_prev[gi];
                    end else if (timer_tick) begin
                        dt_cnt[gi] <= dt_cnt[gi] - 4'h1;
                    end
                end
            end
        end
    endgenerate

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    top_clear_a: assert property (step && at_top && !pfc |=> count == 10'h000)
        else $error("counter not cleared at top match");
    top_min_a: assert property (wr_top && wr_word < timer_pkg::TOP_MIN
        |=> top_compare == timer_pkg::TOP_MIN)
        else $error("top compare below minimum");
    top_store_a: assert property (wr_top && wr_word >= timer_pkg::TOP_MIN
        |=> top_compare == $past(wr_word))
        else $error("top compare write lost");
    d_count_a: assert property (match[timer_pkg::EV_D] |-> $past(step))
        else $error("compare D match without counting");
    sw_nomatch_a: assert property (wr_count |=> !match[timer_pkg::EV_D])
        else $error("software write made compare D match");
    d_flag_a: assert property (match[timer_pkg::EV_D] |-> ##2 ev_flag[timer_pkg::EV_D])
        else $error("compare D flag not set after delay");
    irq_gate_a: assert property (irq_req |-> $past(global_irq_en) && $past(|pending))
        else $error("request without enable and flag");
    vec_d_a: assert property (irq_req && irq_vector == 8'h10
        |-> $past(pending[timer_pkg::EV_D]))
        else $error("compare D vector without pending flag");
    ovf_top_a: assert property (ovf_single |=> ev_flag[timer_pkg::EV_OVF] && count == 10'h000)
        else $error("overflow flag not set at top");
    ovf_bottom_a: assert property (ovf_dual |=> ev_flag[timer_pkg::EV_OVF] && at_bottom)
        else $error("overflow flag not set at bottom");
    w1c_clear_a: assert property (ev_wclr[timer_pkg::EV_D] && !match[timer_pkg::EV_D]
        && !match_sync[timer_pkg::EV_D] |-> ##2 !ev_flag[timer_pkg::EV_D])
        else $error("compare D flag not cleared by write");
    ovf_clear_a: assert property (ev_wclr[timer_pkg::EV_OVF] && !ovf_event
        ##1 !ovf_event |=> !ev_flag[timer_pkg::EV_OVF])
        else $error("overflow flag not cleared by write");
    no_overlap_a: assert property ((out_true & out_compl) == 3'b000)
        else $error("complementary outputs both high");
    dt_wait_a: assert property ($rose(out_true[0]) |-> $past(dt_cnt[0] == 4'h0))
        else $error("true output rose before dead time");

    d_match_c: cover property (match[timer_pkg::EV_D]);
    ovf_dual_c: cover property (ovf_dual);
    ovf_irq_c: cover property (irq_req && irq_vector == timer_pkg::EV_VEC[timer_pkg::EV_OVF]);
    compl_rise_c: cover property ($rose(out_compl[0]));

endmodule

`default_nettype wire

//--- testbench/timer_top_compare_irq_deadtime_tb.sv
// Self-checking bench for the timer top-compare, interrupt-flag and dead-time block.
// Assumes the design's package and the design file are compiled first.
`timescale 1ns/1ps
`default_nettype none

module timer_top_compare_irq_deadtime_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic timer_tick = 1'b0;
    logic global_irq_en = 1'b0;
    logic irq_ack = 1'b0;
    logic irq_req;
    logic [7:0] irq_vector;
    logic [2:0] out_true;
    logic [2:0] out_compl;
    int fail_count = 0;
    int total_checks = 0;
    logic [7:0] rd;

    timer_top_compare_irq_deadtime i_timer_top_compare_irq_deadtime (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_tick(timer_tick),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_vector(irq_vector), .out_true(out_true), .out_compl(out_compl)
    );

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic w10(input logic [7:0] a, input logic [9:0] v);
        wr(timer_pkg::ADDR_HIGH_BYTE, {6'h00, v[9:8]});
        wr(a, v[7:0]);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            timer_tick <= 1'b1;
            @(posedge clk_sys);
            timer_tick <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic ack();
        @(posedge clk_sys);
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq_req !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 20) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, irq_req, 1'b1);
            complete_run();
        end
    endtask

    // Complementary outputs must never be high together
    always @(negedge clk_sys) begin
        if (!rst && (out_true & out_compl) !== 3'h0) begin
            chk({5'h00, out_true & out_compl}, 8'h00);
        end
    end

    task automatic regs_test();
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'h00);
        wr(timer_pkg::ADDR_MASK, 8'he4);
        rdr(timer_pkg::ADDR_MASK, rd);
        chk(rd, 8'he4);
        rdr(8'h30, rd);
        chk(rd, 8'h00);
        w10(timer_pkg::ADDR_TOP, 10'h100);
        wr(timer_pkg::ADDR_HIGH_BYTE, 8'h00);
        rdr(timer_pkg::ADDR_TOP, rd);
        chk(rd, 8'h00);
        rdr(timer_pkg::ADDR_HIGH_BYTE, rd);
        chk(rd, 8'h01);
        w10(timer_pkg::ADDR_TOP, 10'h001);
        rdr(timer_pkg::ADDR_TOP, rd);
        chk(rd, 8'h03);
        wr(timer_pkg::ADDR_MASK, 8'h00);
    endtask

    task automatic overflow_test();
        w10(timer_pkg::ADDR_TOP, 10'h005);
        wr(timer_pkg::ADDR_MODE, 8'h01);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h004);
        ticks(1);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'h00);
        ticks(1);
        rdr(timer_pkg::ADDR_COUNT_LOW, rd);
        chk(rd, 8'h00);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'he4);
        wr(timer_pkg::ADDR_MASK, 8'h04);
        global_irq_en <= 1'b1;
        wait_irq();
        chk(irq_vector, 8'h04);
        ack();
        chk({7'h00, irq_req}, 8'h00);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'he0);
        wr(timer_pkg::ADDR_FLAGS, 8'hff);
        // Fast mode overflows at top like normal mode
        wr(timer_pkg::ADDR_MODE, 8'h03);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h005);
        ticks(1);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'he4);
        wr(timer_pkg::ADDR_FLAGS, 8'hff);
    endtask

    task automatic compare_test();
        w10(timer_pkg::ADDR_CMP_A, 10'h003);
        w10(timer_pkg::ADDR_CMP_B, 10'h003);
        w10(timer_pkg::ADDR_CMP_D, 10'h003);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h003);
        repeat (5) @(posedge clk_sys);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'h00);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h002);
        ticks(1);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'he0);
        wr(timer_pkg::ADDR_FLAGS, 8'h20);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd, 8'hc0);
        wr(timer_pkg::ADDR_MASK, 8'he0);
        wait_irq();
        chk(irq_vector, 8'h03);
        ack();
        chk(irq_vector, 8'h10);
        global_irq_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({7'h00, irq_req}, 8'h00);
        global_irq_en <= 1'b1;
        wait_irq();
        ack();
        chk({7'h00, irq_req}, 8'h00);
        wr(timer_pkg::ADDR_MASK, 8'h20);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h002);
        ticks(1);
        wait_irq();
        chk(irq_vector, 8'h09);
        wr(timer_pkg::ADDR_FLAGS, 8'hff);
        global_irq_en <= 1'b0;
    endtask

    task automatic pfc_test();
        w10(timer_pkg::ADDR_TOP, 10'h003);
        wr(timer_pkg::ADDR_MODE, 8'h05);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h000);
        wr(timer_pkg::ADDR_FLAGS, 8'hff);
        ticks(3);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd & 8'h04, 8'h00);
        ticks(3);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd & 8'h04, 8'h04);
        wr(timer_pkg::ADDR_FLAGS, 8'h04);
        rdr(timer_pkg::ADDR_FLAGS, rd);
        chk(rd & 8'h04, 8'h00);
    endtask

    task automatic dead_time_test();
        wr(timer_pkg::ADDR_MODE, 8'h00);
        wr(timer_pkg::ADDR_DEAD_TIME, 8'h21);
        rdr(timer_pkg::ADDR_DEAD_TIME, rd);
        chk(rd, 8'h21);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h005);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({2'h0, out_true, out_compl}, 8'h00);
        ticks(3);
        chk({5'h00, out_compl}, 8'h07);
        w10(timer_pkg::ADDR_COUNT_LOW, 10'h000);
        repeat (2) @(posedge clk_sys);
        ticks(1);
        chk({5'h00, out_true}, 8'h00);
        ticks(3);
        chk({5'h00, out_true}, 8'h07);
    endtask

    initial begin
        #500us;
        fail_count++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        regs_test();
        overflow_test();
        compare_test();
        pfc_test();
        dead_time_test();
        complete_run();
    end
endmodule

`default_nettype wire
